/* core/mwa_memory_word_access.sv */
// Purpose: Word level memory command executor behind an Avalon-MM slave.
// Assumes: Memory controller on clk answers each request with a mem_ack pulse.
// Notes:   Busy commands and data writes while busy are ignored.
// Contract
// - Host writes 5-bit command code; operand goes in 16-bit data register.
// - Binary read returns word at file pointer, advances it; errors on bad state.
// - Binary write stores data word at file pointer, then advances pointer.
// - Binary write errors on range, voice prompt space, full memory, audio file.
// - On flash, overwriting existing file words can only turn zeros into ones.
// - Descriptor read returns selected entry in data register, never errors.
// - Direct commands are rejected with error while a file is open.
// - Set address loads pointer bits 8 to 23, clears bits 0 to 7.
// - Direct read fetches word at direct pointer, then increments pointer.
// - Direct write stores data word at direct pointer, then increments it.
// - Block erase erases flash block at pointer; errors if open or not flash.
// - Any command start may be postponed by up to 30 ms.
// - Immediate bit with idle signal processing starts the command at once.
// - Busy flag stands while a command executes, clears on completion.
`timescale 1ns/1ps
`default_nettype none
module mwa_memory_word_access
  import mwa_pkg::*;
#(
  parameter int DELAY_CYC = START_DELAY_CYC
) (
  input  wire logic        clk,             // 250 MHz clock
  input  wire logic        arst_n,          // Async reset, low
  input  wire logic [7:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  output mwa_mem_t         mem,             // Memory request
  input  wire logic [15:0] mem_rdata,       // Memory read data
  input  wire logic        mem_ack,         // Memory done pulse
  input  wire logic        dsp_idle,        // Coder, decoder, detector idle
  output logic             busy_flag,       // Command running
  output logic             irq              // Level interrupt
);

  localparam int CW = $clog2(DELAY_CYC + 1) + 1;

  mwa_state_t  state;
  logic        resp_q;
  logic [31:0] rdata_q;
  logic [4:0]  cmd_q;
  logic        imm_q;
  logic [15:0] cdata;
  mwa_cfg_t    cfg;
  logic [23:0] fbase;
  logic [23:0] dbase;
  logic [15:0] fptr;
  logic [15:0] flen;
  logic [23:0] direct_address_pointer;
  logic [CW-1:0] cnt;
  logic        err_q;
  logic        err_flag;
  logic [1:0]  irq_st;
  logic [1:0]  irq_mask;
  logic        acc_wr;
  logic        acc_cmd;
  logic        exec_err;
  logic        merge;
  // All checks below run on clk and stand down in reset
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Error decode for the command about to run
  function automatic logic cmd_error(input logic [4:0] c, input mwa_cfg_t f,
                                     input logic [15:0] p, input logic [15:0] l);
    case (c)
      CMD_BIN_RD:   cmd_error = !f.binary || f.audio || f.phrase || (p >= l);
      CMD_BIN_WR:   cmd_error = !f.binary || f.audio || f.vprompt || f.full
                                || (f.existing && (p >= l));
      CMD_DESC_RD:  cmd_error = 1'b0;
      CMD_SET_ADDR: cmd_error = f.file_open;
      CMD_DMA_RD:   cmd_error = f.file_open;
      CMD_DMA_WR:   cmd_error = f.file_open;
      CMD_ERASE:    cmd_error = f.file_open || (f.mem != MEM_FLASH);
      default:      cmd_error = 1'b1;
    endcase
  endfunction

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !resp_q;
  assign acc_wr          = avs_write && resp_q;
  assign acc_cmd         = acc_wr && (avs_address == OFF_CMD) && (state == ST_IDLE);
  assign exec_err        = cmd_error(cmd_q, cfg, fptr, flen);
  // Flash cannot clear bits, so existing words are read and ORed
  assign merge           = (cfg.mem == MEM_FLASH) && cfg.existing && (fptr < flen);
  assign busy_flag       = (state != ST_IDLE);
  assign irq             = |(irq_st & irq_mask);

  // Bus response phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= (avs_read || avs_write) && !resp_q;
    end
  end

  // Read mux, captured in the wait cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read && !resp_q) begin
      case (avs_address)
        OFF_CMD:   rdata_q <= {26'h0000000, imm_q, cmd_q};
        OFF_DATA:  rdata_q <= {16'h0000, cdata};
        OFF_STAT:  rdata_q <= {30'h00000000, err_flag, busy_flag};
        OFF_IRQ:   rdata_q <= {30'h00000000, irq_st};
        OFF_MASK:  rdata_q <= {30'h00000000, irq_mask};
        OFF_CFG:   rdata_q <= {23'h000000, cfg};
        OFF_FBASE: rdata_q <= {8'h00, fbase};
        OFF_FPTR:  rdata_q <= {16'h0000, fptr};
        OFF_FLEN:  rdata_q <= {16'h0000, flen};
        OFF_DBASE: rdata_q <= {8'h00, dbase};
        OFF_DIRECT_ADDRESS_POINTER:  rdata_q <= {8'h00, direct_address_pointer};
        default:   rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign avs_readdata = resp_q ? rdata_q : 32'h00000000;

  // Command register, taken only when idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= 5'h00;
      imm_q <= 1'b0;
    end else if (acc_cmd && avs_byteenable[0]) begin
      cmd_q <= avs_writedata[CMD_W-1:0];
      imm_q <= avs_writedata[IMM_BIT];
    end
  end

  // Configuration, only changed while idle to keep decode stable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg      <= CFG_RST;
      fbase    <= ADDR_RST;
      dbase    <= ADDR_RST;
      irq_mask <= IRQ_RST;
    end else if (acc_wr && state == ST_IDLE) begin
      case (avs_address)
        OFF_CFG:   cfg <= {avs_byteenable[1] ? avs_writedata[8] : cfg[8],
                           avs_byteenable[0] ? avs_writedata[7:0] : cfg[7:0]};
        OFF_FBASE: fbase <= {avs_byteenable[2] ? avs_writedata[23:16] : fbase[23:16],
                             merge16(fbase[15:0], avs_writedata, avs_byteenable)};
        OFF_DBASE: dbase <= {avs_byteenable[2] ? avs_writedata[23:16] : dbase[23:16],
                             merge16(dbase[15:0], avs_writedata, avs_byteenable)};
        OFF_MASK:  irq_mask <= avs_byteenable[0] ? avs_writedata[1:0] : irq_mask;
        default:   irq_mask <= irq_mask;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt   <= '0;
      err_q <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (acc_cmd) begin
            if (avs_writedata[IMM_BIT] && dsp_idle) begin
              state <= ST_EXEC;
            end else begin
              state <= ST_WAIT;
              cnt   <= CW'(DELAY_CYC - 1);
            end
          end
        end
        ST_WAIT: begin
          // Worst case start delay, counted in full
          if (cnt == '0) begin
            state <= ST_EXEC;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_EXEC: begin
          err_q <= exec_err;
          if (exec_err) begin
            state <= ST_DONE;
          end else begin
            case (cmd_q)
              CMD_DESC_RD, CMD_BIN_RD, CMD_DMA_RD: state <= ST_RD;
              CMD_BIN_WR: state <= merge ? ST_RD : ST_WR;
              CMD_DMA_WR, CMD_ERASE: state <= ST_WR;
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_RD: begin
          if (mem_ack) begin
            state <= (cmd_q == CMD_BIN_WR) ? ST_WR : ST_DONE;
          end
        end
        ST_WR: begin
          if (mem_ack) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory request, held until acknowledged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem <= '0;
    end else if (state == ST_EXEC && !exec_err) begin
      mem.req   <= (cmd_q != CMD_SET_ADDR);
      mem.we    <= (cmd_q == CMD_DMA_WR) || (cmd_q == CMD_BIN_WR && !merge);
      mem.erase <= (cmd_q == CMD_ERASE);
      mem.wdata <= cdata;
      case (cmd_q)
        CMD_DESC_RD:            mem.addr <= dbase + {20'h00000, cdata[3:0]};
        CMD_BIN_RD, CMD_BIN_WR: mem.addr <= fbase + {8'h00, fptr};
        default:                mem.addr <= direct_address_pointer;
      endcase
    end else if (state == ST_RD && mem_ack && cmd_q == CMD_BIN_WR) begin
      mem.we    <= 1'b1;
      mem.wdata <= mem_rdata | cdata;
    end else if (mem_ack) begin
      mem.req <= 1'b0;
    end
  end

  // Data register: host operand or command result
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cdata <= DATA_RST;
    end else if (state == ST_RD && mem_ack && cmd_q != CMD_BIN_WR) begin
      cdata <= mem_rdata;
    end else if (acc_wr && state == ST_IDLE && avs_address == OFF_DATA) begin
      cdata <= merge16(cdata, avs_writedata, avs_byteenable);
    end
  end

  // File pointer and length; host write stands in for a seek
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fptr <= DATA_RST;
      flen <= DATA_RST;
    end else if (mem_ack && state == ST_RD && cmd_q == CMD_BIN_RD) begin
      fptr <= fptr + 16'h0001;
    end else if (mem_ack && state == ST_WR && cmd_q == CMD_BIN_WR) begin
      fptr <= fptr + 16'h0001;
      if (fptr >= flen) begin
        flen <= fptr + 16'h0001;
      end
    end else if (acc_wr && state == ST_IDLE) begin
      if (avs_address == OFF_FPTR) begin
        fptr <= merge16(fptr, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_FLEN) begin
        flen <= merge16(flen, avs_writedata, avs_byteenable);
      end
    end
  end

  // Direct address pointer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      direct_address_pointer <= ADDR_RST;
    end else if (state == ST_EXEC && !exec_err && cmd_q == CMD_SET_ADDR) begin
      direct_address_pointer <= {cdata, 8'h00};
    end else if (mem_ack && ((state == ST_RD && cmd_q == CMD_DMA_RD)
                             || (state == ST_WR && cmd_q == CMD_DMA_WR))) begin
      direct_address_pointer <= direct_address_pointer + 24'h000001;
    end
  end

  // Error status stands until the next command is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_flag <= 1'b0;
    end else if (state == ST_DONE) begin
      err_flag <= err_q;
    end else if (acc_cmd) begin
      err_flag <= 1'b0;
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st <= IRQ_RST;
    end else begin
      irq_st <= (irq_st & ~((acc_wr && avs_address == OFF_IRQ && avs_byteenable[0])
                            ? avs_writedata[1:0] : 2'h0))
                | ((state == ST_DONE) ? {err_q, 1'b1} : 2'h0);
    end
  end

  // Command sequencing checks, clocked by the default above
  property p_set_addr;
    (state == ST_EXEC && cmd_q == CMD_SET_ADDR && !cfg.file_open)
      |=> (direct_address_pointer == {$past(cdata), 8'h00});
  endproperty
  a_set_addr: assert property (p_set_addr) else $error("set address wrong");
  property p_dma_rd_inc;
    (state == ST_RD && mem_ack && cmd_q == CMD_DMA_RD)
      |=> (direct_address_pointer == $past(direct_address_pointer) + 24'h000001)
          && (cdata == $past(mem_rdata));
  endproperty
  a_dma_rd_inc: assert property (p_dma_rd_inc) else $error("direct read wrong");
  property p_dma_wr;
    (state == ST_EXEC && cmd_q == CMD_DMA_WR && !cfg.file_open)
      |=> mem.req && mem.we && (mem.addr == direct_address_pointer) && (mem.wdata == cdata);
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("direct write request wrong");
  property p_open_reject;
    (state == ST_EXEC && cfg.file_open && (cmd_q == CMD_DMA_RD || cmd_q == CMD_ERASE))
      |=> (state == ST_DONE && !mem.req) ##1 (err_flag && irq_st[IRQ_ERR]);
  endproperty
  a_open_reject: assert property (p_open_reject) else $error("file open not rejected");
  property p_erase_ram;
    (state == ST_EXEC && cmd_q == CMD_ERASE && cfg.mem != MEM_FLASH) |=> !mem.req [*2];
  endproperty
  a_erase_ram: assert property (p_erase_ram) else $error("erase on ram");
  property p_delay;
    (acc_cmd && !(avs_writedata[IMM_BIT] && dsp_idle)) |=> (state == ST_WAIT) [*8];
  endproperty
  a_delay: assert property (p_delay) else $error("start delay skipped");
  property p_imm;
    (acc_cmd && avs_writedata[IMM_BIT] && dsp_idle) |=> (state == ST_EXEC) && busy_flag;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate start missed");
  property p_merge;
    (state == ST_RD && mem_ack && cmd_q == CMD_BIN_WR) |=> mem.we && (mem.wdata == ($past(mem_rdata) | cdata));
  endproperty
  a_merge: assert property (p_merge) else $error("flash merge wrong");
  property p_bin_err;
    (state == ST_EXEC && cmd_q == CMD_BIN_RD && cfg.audio) |=> !mem.req && $stable(fptr) ##1 (err_flag && !busy_flag);
  endproperty
  a_bin_err: assert property (p_bin_err) else $error("binary read error missed");
  property p_desc_ok;
    (state == ST_EXEC && cmd_q == CMD_DESC_RD) |=> mem.req && !err_q;
  endproperty
  a_desc_ok: assert property (p_desc_ok) else $error("descriptor read errored");

endmodule
`default_nettype wire

/* core/mwa_pkg.sv */
// Purpose: Shared constants and types for the memory word access block.
// Assumes: 32-bit Avalon-MM slave, byte addressed, one word per register.
// Notes:   Command codes and offsets are local choices of this design.
package mwa_pkg;

  // Clock and start delay
  localparam int CLK_MHZ         = 250;
  localparam int START_DELAY_MS  = 30;
  localparam int START_DELAY_CYC = START_DELAY_MS * CLK_MHZ * 1000;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_DATA  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_IRQ   = 8'h0C;
  localparam logic [7:0] OFF_MASK  = 8'h10;
  localparam logic [7:0] OFF_CFG   = 8'h14;
  localparam logic [7:0] OFF_FBASE = 8'h18;
  localparam logic [7:0] OFF_FPTR  = 8'h1C;
  localparam logic [7:0] OFF_FLEN  = 8'h20;
  localparam logic [7:0] OFF_DBASE = 8'h24;
  localparam logic [7:0] OFF_DIRECT_ADDRESS_POINTER  = 8'h28;

  // Command register fields
  localparam int CMD_W   = 5;
  localparam int IMM_BIT = 5;

  // Command codes
  localparam logic [4:0] CMD_DESC_RD  = 5'h0A;
  localparam logic [4:0] CMD_BIN_RD   = 5'h0B;
  localparam logic [4:0] CMD_BIN_WR   = 5'h0C;
  localparam logic [4:0] CMD_SET_ADDR = 5'h10;
  localparam logic [4:0] CMD_DMA_RD   = 5'h11;
  localparam logic [4:0] CMD_DMA_WR   = 5'h12;
  localparam logic [4:0] CMD_ERASE    = 5'h13;

  // Memory kinds
  localparam logic [1:0] MEM_FLASH = 2'h0;
  localparam logic [1:0] MEM_AUDIO_GRADE_RAM  = 2'h1;
  localparam logic [1:0] MEM_DRAM  = 2'h2;

  // Status and interrupt bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR  = 1;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;

  // Reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [1:0]  IRQ_RST  = 2'h0;

  // File and memory configuration, lowest bits last
  typedef struct packed {
    logic       existing;
    logic       full;
    logic       vprompt;
    logic       phrase;
    logic       audio;
    logic       binary;
    logic       file_open;
    logic [1:0] mem;
  } mwa_cfg_t;

  localparam logic [8:0] CFG_RST = 9'h000;

  // Request towards the external memory controller
  typedef struct packed {
    logic        req;
    logic        we;
    logic        erase;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mwa_mem_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_EXEC = 3'h2,
    ST_RD   = 3'h3,
    ST_WR   = 3'h4,
    ST_DONE = 3'h5
  } mwa_state_t;

endpackage

/* dv/mwa_mem_model.sv */
// Purpose: Behavioural external voice memory for the word access block.
// Assumes: One word per request, ack after lat waiting cycles.
// Notes:   Erase clears a 16-word block; idle read data toggles.
`timescale 1ns/1ps
`default_nettype none
module mwa_mem_model
  import mwa_pkg::*;
(
  input  wire logic       clk,    // Clock
  input  wire logic       arst_n, // Async reset, low
  input  wire mwa_mem_t   mem,    // Request
  input  wire logic [3:0] lat,    // Answer delay
  output logic     [15:0] rdata,  // Read data
  output logic            ack     // Done pulse
);
  logic [15:0] store [logic [23:0]];
  logic [3:0]  cnt;
  // One ack per request; data toggles between answers so stale reads fail
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack   <= 1'b0;
      cnt   <= 4'h0;
      rdata <= 16'h0000;
    end else begin
      ack   <= 1'b0;
      rdata <= ~rdata;
      if (mem.req && !ack && cnt >= lat) begin
        ack <= 1'b1;
        cnt <= 4'h0;
        if (mem.erase) begin
          foreach (store[k]) begin
            if (k[23:4] == mem.addr[23:4]) store[k] = 16'h0000;
          end
        end else if (mem.we) begin
          // Page buffering is not modelled, so each word lands at once
          store[mem.addr] = mem.wdata;
        end else begin
          rdata <= store.exists(mem.addr) ? store[mem.addr] : 16'h0000;
        end
      end else if (mem.req && !ack) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/test_memory_word_access.sv */
// Purpose: Self-checking bench for the memory word access block.
// Assumes: Short start delay, byte lanes all enabled.
// Notes:   Expected words come from preloaded model contents and the bench's own writes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_memory_word_access
  import mwa_pkg::*;
;
  localparam int DLY = 16;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  mwa_mem_t    mem;
  logic [15:0] mem_rdata;
  logic        mem_ack;
  logic        dsp_idle = 1'b1;
  logic        busy_flag;
  logic        irq;
  logic [3:0]  lat = 4'h0;
  logic [31:0] q;
  int          cyc;
  int          errors = 0;
  int          checked = 0;
  logic [7:0]  offs [6] = '{OFF_DATA, OFF_STAT, OFF_IRQ, OFF_DIRECT_ADDRESS_POINTER, OFF_CFG, 8'h40};
  logic [8:0]  bad [5] = '{9'h10C, 9'h04C, 9'h08C, 9'h01C, 9'h004};
  logic [8:0]  rbad [2] = '{9'h01C, 9'h02C};

  mwa_memory_word_access #(.DELAY_CYC(DLY)) u_dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem(mem),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dsp_idle(dsp_idle),
    .busy_flag(busy_flag), .irq(irq));

  mwa_mem_model u_mem (
    .clk(clk), .arst_n(arst_n), .mem(mem), .lat(lat), .rdata(mem_rdata), .ack(mem_ack));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Verdict and end of run
  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    w = 1'b1;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= is_wr;
    avs_read      <= !is_wr;
    // Settled mid-cycle values, then the edge that samples them
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
      @(posedge clk);
    end while (w !== 1'b0 && n < 40);
    if (w !== 1'b0) begin
      errors++;
      wrap_up();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Issue a command, count busy cycles, then check the error flag
  task automatic cmd(input logic [5:0] c, input logic e);
    int n;
    n = 0;
    wr(OFF_CMD, {26'h0, c});
    // Busy is read mid-cycle, away from the edge that moves it
    @(negedge clk);
    while (busy_flag !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    cyc = n;
    if (n >= 200) begin
      errors++;
      wrap_up();
    end
    @(posedge clk);
    rd(OFF_STAT);
    `CHK(q[1:0], {e, 1'b0})
  endtask

  // Main sequence
  initial begin
    u_mem.store[24'h000200] = 16'h1111;
    u_mem.store[24'h000201] = 16'h00F0;
    u_mem.store[24'h000303] = 16'hA5A5;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK(q, 32'h0)
    end
    // Pointer load and direct writes, second one slow
    wr(OFF_DATA, 32'h1234);
    cmd({1'b1, CMD_SET_ADDR}, 1'b0);
    `CHK(cyc < DLY, 1'b1)
    rd(OFF_DIRECT_ADDRESS_POINTER);
    `CHK(q, 32'h00123400)
    wr(OFF_DATA, 32'hBEEF);
    cmd({1'b1, CMD_DMA_WR}, 1'b0);
    lat <= 4'h9;
    wr(OFF_DATA, 32'h0F0F);
    cmd({1'b1, CMD_DMA_WR}, 1'b0);
    lat <= 4'h0;
    `CHK(u_mem.store[24'h123400], 16'hBEEF)
    `CHK(u_mem.store[24'h123401], 16'h0F0F)
    rd(OFF_DIRECT_ADDRESS_POINTER);
    `CHK(q, 32'h00123402)
    // Delayed start, and immediate bit refused while signal path busy
    wr(OFF_DATA, 32'h1234);
    cmd({1'b0, CMD_SET_ADDR}, 1'b0);
    `CHK(cyc >= DLY, 1'b1)
    dsp_idle <= 1'b0;
    cmd({1'b1, CMD_DMA_RD}, 1'b0);
    `CHK(cyc >= DLY, 1'b1)
    dsp_idle <= 1'b1;
    rd(OFF_DATA);
    `CHK(q, 32'hBEEF)
    rd(OFF_DIRECT_ADDRESS_POINTER);
    `CHK(q, 32'h00123401)
    // Erase refused on RAM, done on flash; direct access with file open
    wr(OFF_CFG, 32'h1);
    cmd({1'b1, CMD_ERASE}, 1'b1);
    `CHK(u_mem.store[24'h123400], 16'hBEEF)
    wr(OFF_CFG, 32'h0);
    cmd({1'b1, CMD_ERASE}, 1'b0);
    `CHK(u_mem.store[24'h123400], 16'h0000)
    wr(OFF_CFG, 32'h4);
    cmd({1'b1, CMD_DMA_RD}, 1'b1);
    rd(OFF_DIRECT_ADDRESS_POINTER);
    `CHK(q, 32'h00123401)
    // Interrupt status, mask and write-one clear
    rd(OFF_IRQ);
    `CHK(q[1:0], 2'h3)
    `CHK(irq, 1'b0)
    wr(OFF_MASK, 32'h2);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ, 32'h2);
    `CHK(irq, 1'b0)
    rd(OFF_IRQ);
    `CHK(q[1:0], 2'h1)
    // Binary file reads and merged flash write
    wr(OFF_CFG, 32'h0C);
    wr(OFF_FBASE, 32'h200);
    wr(OFF_FPTR, 32'h0);
    wr(OFF_FLEN, 32'h2);
    cmd({1'b1, CMD_BIN_RD}, 1'b0);
    rd(OFF_DATA);
    `CHK(q, 32'h1111)
    // Audio and phrase files refuse reads while the pointer is in range
    foreach (rbad[i]) begin
      wr(OFF_CFG, {23'h0, rbad[i]});
      cmd({1'b1, CMD_BIN_RD}, 1'b1);
    end
    wr(OFF_CFG, 32'h10C);
    wr(OFF_DATA, 32'h0F00);
    cmd({1'b1, CMD_BIN_WR}, 1'b0);
    `CHK(u_mem.store[24'h000201], 16'h0FF0)
    rd(OFF_FPTR);
    `CHK(q, 32'h2)
    wr(OFF_CFG, 32'h0C);
    cmd({1'b1, CMD_BIN_RD}, 1'b1);
    foreach (bad[i]) begin
      wr(OFF_CFG, {23'h0, bad[i]});
      cmd({1'b1, CMD_BIN_WR}, 1'b1);
    end
    rd(OFF_FPTR);
    `CHK(q, 32'h2)
    // Descriptor read never errors, even on an audio file
    wr(OFF_CFG, 32'h1C);
    wr(OFF_DBASE, 32'h300);
    wr(OFF_DATA, 32'h3);
    cmd({1'b1, CMD_DESC_RD}, 1'b0);
    rd(OFF_DATA);
    `CHK(q, 32'hA5A5)
    cmd(6'h3F, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
